// ### rtl/erase_result_consts.svh
// How it works
// [R1] Bit 6 set when write-enable pin low or error protection active at request.
// [R2] Bit 6 cleared only when write-enable pin is 1 and error flag is 0.
// [R3] Bit 5 set when array erase fails or control settings changed mid-erase.
// [R4] Array select 0xaa (boot array): flag bit 5, erase nothing.
// [R5] Caller should treat array as partly erased after bit 5, fix, erase again.
// [R6] Key compared with 0x5a before erasing; any other value sets bit 4.
// [R7] Bit 3 set when block number outside user array range, else cleared.
// [R8] Bits 7, 2 and 1 always read zero.
// [R9] Bit 0 is overall outcome: 0 success, 1 abnormal end.
// [R10] Result byte returned to caller as low byte of register zero when done.
// [R11] One block per request; valid 0 to 10 and 12 to 23.
// [R12] All error bits evaluated before the byte; any error sets bit 0.
`ifndef ERASE_RESULT_CONSTS_SVH
`define ERASE_RESULT_CONSTS_SVH
`define BIT_MODE_ERR 6
`define BIT_EXEC_ERR 5
`define BIT_KEY_ERR 4
`define BIT_BLOCK_ERR 3
`define BIT_FAIL 0
`define KEY_VALID 8'h5a
`define ARRAY_SEL_BOOT 8'haa
`define BLOCK_LO_MAX 8'h0a
`define BLOCK_HI_MIN 8'h0c
`define BLOCK_HI_MAX 8'h17
`define RESULT_USED_MASK 8'h79
`define RESULT_ERR_MASK 8'h78
`define BLOCK_HOLE 8'h0b
`endif

// ### rtl/erase_result_pkg.sv
package erase_result_pkg;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_ERASE = 2'b01,
      ST_DONE = 2'b11
   } seq_state_type;
endpackage

// ### rtl/block_range_check.sv
`timescale 1ns/10ps
`include "erase_result_consts.svh"
module block_range_check
(
   input wire logic [7:0] block_num_i,
   output logic bad_o
);
   // Block 11 is a hole in the user array
   always_comb
   begin
      bad_o = !((block_num_i <= `BLOCK_LO_MAX) ||
                (block_num_i >= `BLOCK_HI_MIN && block_num_i <= `BLOCK_HI_MAX)); // see [R11] see [R7]
   end
endmodule

// ### rtl/flash_erase_result_status.sv
`timescale 1ns/10ps
`include "erase_result_consts.svh"
module flash_erase_result_status
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic erase_req_i,
   input wire logic [7:0] block_num_i,
   input wire logic flash_write_enable_pin_i,
   input wire logic flash_error_flag_i,
   input wire logic [7:0] flash_key_register_i,
   input wire logic [7:0] array_select_register_i,
   input wire logic ctrl_changed_i,
   input wire logic erase_done_i,
   input wire logic erase_fail_i,
   output logic erase_start_o,
   output logic busy_o,
   output logic result_valid_o,
   output logic [7:0] erase_result_byte_o
);
   erase_result_pkg::seq_state_type state_r;
   logic [2:0] wen_sync_r;
   logic wen_level_r;
   logic wen_ok;
   logic block_bad;
   logic mode_err;
   logic key_err;
   logic boot_sel;
   logic pre_err;
   logic req_taken;
   logic block_ok_chk;
   logic exec_err_r;
   logic [7:0] pre_r;
   logic [7:0] erase_result_byte_nxt;

   // Pin crosses in three stages; level taken once stages two and three agree
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         wen_sync_r <= 3'h0;
      else
         wen_sync_r <= {wen_sync_r[1:0], flash_write_enable_pin_i};
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         wen_level_r <= 1'b0;
      else if (wen_sync_r[1] == wen_sync_r[2])
         wen_level_r <= wen_sync_r[2];
   end
   assign wen_ok = wen_level_r;

   a_wen_agree: assert property (@(posedge clk_i) disable iff (rst_i) // see [R1]
      (wen_sync_r[1] == wen_sync_r[2]) |=> (wen_level_r == $past(wen_sync_r[2])))
      else $error("Pin level not taken after agreement");
   a_wen_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see [R2]
      (wen_sync_r[1] != wen_sync_r[2]) |=> $stable(wen_level_r))
      else $error("Pin level moved without agreement");

   block_range_check u_range
   (
      .block_num_i(block_num_i),
      .bad_o(block_bad)
   );

   assign mode_err = !wen_ok || flash_error_flag_i; // see [R1] see [R2]
   assign key_err = flash_key_register_i != `KEY_VALID; // see [R6]
   assign boot_sel = array_select_register_i == `ARRAY_SEL_BOOT; // see [R4]
   assign pre_err = mode_err || key_err || block_bad || boot_sel;
   assign req_taken = state_r == erase_result_pkg::ST_IDLE && erase_req_i;
   // Range worked out apart from u_range, for the checks only
   assign block_ok_chk = block_num_i <= `BLOCK_LO_MAX ||
                         (block_num_i >= `BLOCK_HI_MIN && block_num_i <= `BLOCK_HI_MAX);

   a_start_checks: assert property (@(posedge clk_i) disable iff (rst_i) // see [R6] see [R11]
      erase_start_o |-> wen_ok && !flash_error_flag_i && flash_key_register_i == `KEY_VALID && block_ok_chk)
      else $error("Erase started with a failed check");
   a_start_all_ok: assert property (@(posedge clk_i) disable iff (rst_i) // see [R11]
      (req_taken && wen_ok && !flash_error_flag_i && flash_key_register_i == `KEY_VALID && block_ok_chk
       && array_select_register_i != `ARRAY_SEL_BOOT) |-> erase_start_o)
      else $error("Erase not started with all checks passed");

   // Sequencer: checks first, then erase only if all checks pass
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         state_r <= erase_result_pkg::ST_IDLE;
      else
         case (state_r)
            erase_result_pkg::ST_IDLE:
               if (erase_req_i)
                  state_r <= pre_err ? erase_result_pkg::ST_DONE : erase_result_pkg::ST_ERASE; // see [R4]
            erase_result_pkg::ST_ERASE:
               if (erase_done_i)
                  state_r <= erase_result_pkg::ST_DONE;
            erase_result_pkg::ST_DONE:
               state_r <= erase_result_pkg::ST_IDLE;
            default:
               state_r <= erase_result_pkg::ST_IDLE;
         endcase
   end

   a_busy_refused: assert property (@(posedge clk_i) disable iff (rst_i) // see [R11]
      (state_r == erase_result_pkg::ST_ERASE && !erase_done_i) |=> state_r == erase_result_pkg::ST_ERASE)
      else $error("Erase phase left without done");
   a_done_once: assert property (@(posedge clk_i) disable iff (rst_i) // see [R10]
      state_r == erase_result_pkg::ST_DONE |=> state_r == erase_result_pkg::ST_IDLE)
      else $error("Done state held too long");
   a_precheck_stop: assert property (@(posedge clk_i) disable iff (rst_i) // see [R4]
      (req_taken && pre_err) |=> state_r == erase_result_pkg::ST_DONE)
      else $error("Erase phase entered after failed check");

   // Pre-check bits captured at request time
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         pre_r <= 8'h00;
      else if (state_r == erase_result_pkg::ST_IDLE && erase_req_i)
      begin
         pre_r <= 8'h00;
         pre_r[`BIT_MODE_ERR] <= mode_err; // see [R1] see [R2]
         pre_r[`BIT_KEY_ERR] <= key_err; // see [R6]
         pre_r[`BIT_BLOCK_ERR] <= block_bad; // see [R7]
         pre_r[`BIT_EXEC_ERR] <= boot_sel; // see [R4]
      end
   end

   a_key_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see [R6]
      (req_taken && flash_key_register_i == `KEY_VALID && pre_err) |-> ##2 result_valid_o && !erase_result_byte_o[4])
      else $error("Key error set with valid key");
   a_block_high: assert property (@(posedge clk_i) disable iff (rst_i) // see [R7]
      (req_taken && block_num_i > `BLOCK_HI_MAX) |-> ##2 result_valid_o && erase_result_byte_o[3])
      else $error("High block number not flagged");
   a_block_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see [R7]
      (req_taken && block_ok_chk && pre_err) |-> ##2 result_valid_o && !erase_result_byte_o[3])
      else $error("Block error set for valid block");
   a_boot_exec: assert property (@(posedge clk_i) disable iff (rst_i) // see [R4]
      (req_taken && array_select_register_i == `ARRAY_SEL_BOOT)
      |-> ##2 result_valid_o && erase_result_byte_o[5] && erase_result_byte_o[0])
      else $error("Boot array select not flagged");
   a_pin_low: assert property (@(posedge clk_i) disable iff (rst_i) // see [R1]
      (req_taken && !wen_ok) |-> ##2 result_valid_o && erase_result_byte_o[6])
      else $error("Low enable pin not flagged");

   // Execution error from array failure or control change during erase
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         exec_err_r <= 1'b0;
      else if (state_r == erase_result_pkg::ST_IDLE && erase_req_i)
         exec_err_r <= 1'b0;
      else if (state_r == erase_result_pkg::ST_ERASE && (ctrl_changed_i || (erase_done_i && erase_fail_i)))
         exec_err_r <= 1'b1; // see [R3]
   end

   a_ctrl_change: assert property (@(posedge clk_i) disable iff (rst_i) // see [R3]
      (state_r == erase_result_pkg::ST_ERASE && ctrl_changed_i) |=> exec_err_r)
      else $error("Control change not recorded");
   a_exec_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see [R3]
      req_taken |=> !exec_err_r)
      else $error("Execution error not cleared on request");

   always_comb
   begin
      erase_result_byte_nxt = pre_r;
      erase_result_byte_nxt[`BIT_EXEC_ERR] = pre_r[`BIT_EXEC_ERR] | exec_err_r; // see [R3]
      erase_result_byte_nxt[`BIT_FAIL] = |(erase_result_byte_nxt & `RESULT_ERR_MASK); // see [R12] see [R9]
      erase_result_byte_nxt = erase_result_byte_nxt & `RESULT_USED_MASK; // see [R8]
   end

   // Byte handed to caller when processing finishes
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         erase_result_byte_o <= 8'h00;
      else if (state_r == erase_result_pkg::ST_DONE)
         erase_result_byte_o <= erase_result_byte_nxt; // see [R10]
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         result_valid_o <= 1'b0;
      else
         result_valid_o <= state_r == erase_result_pkg::ST_DONE; // see [R10]
   end

   assign erase_start_o = req_taken && !pre_err; // see [R4]
   assign busy_o = state_r != erase_result_pkg::ST_IDLE;

   a_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i) // see [R8]
      (erase_result_byte_o & ~`RESULT_USED_MASK) == 8'h00)
      else $error("Unused result bits not zero");
   a_fail_any_err: assert property (@(posedge clk_i) disable iff (rst_i) // see [R12]
      result_valid_o |-> (erase_result_byte_o[0] == |erase_result_byte_o[6:3]))
      else $error("Fail bit mismatch");
   a_success_zero: assert property (@(posedge clk_i) disable iff (rst_i) // see [R9]
      (result_valid_o && erase_result_byte_o[6:3] == 4'h0) |-> !erase_result_byte_o[0])
      else $error("Fail bit set without error");
   a_key_checked: assert property (@(posedge clk_i) disable iff (rst_i) // see [R6]
      (req_taken && flash_key_register_i != `KEY_VALID) |-> ##2 result_valid_o && erase_result_byte_o[4])
      else $error("Key error not reported");
   a_boot_noerase: assert property (@(posedge clk_i) disable iff (rst_i) // see [R4]
      erase_start_o |-> array_select_register_i != `ARRAY_SEL_BOOT)
      else $error("Boot array erase started");
   a_mode_err: assert property (@(posedge clk_i) disable iff (rst_i) // see [R1]
      (req_taken && flash_error_flag_i) |-> ##2 result_valid_o && erase_result_byte_o[6])
      else $error("Mode error not reported");
   a_mode_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see [R2]
      (req_taken && wen_ok && !flash_error_flag_i && pre_err) |-> ##2 result_valid_o && !erase_result_byte_o[6])
      else $error("Mode error set wrongly");
   a_mode_erased: assert property (@(posedge clk_i) disable iff (rst_i) // see [R2]
      (state_r == erase_result_pkg::ST_ERASE && erase_done_i) |-> ##2 result_valid_o && !erase_result_byte_o[6])
      else $error("Mode error set after erase");
   a_block_err: assert property (@(posedge clk_i) disable iff (rst_i) // see [R7]
      (req_taken && block_num_i == `BLOCK_HOLE) |-> ##2 result_valid_o && erase_result_byte_o[3])
      else $error("Block 11 not flagged");
   a_exec_fail: assert property (@(posedge clk_i) disable iff (rst_i) // see [R3]
      (state_r == erase_result_pkg::ST_ERASE && erase_done_i && erase_fail_i)
      |-> ##2 erase_result_byte_o[5] && erase_result_byte_o[0])
      else $error("Exec error not reported");
   a_erase_clean: assert property (@(posedge clk_i) disable iff (rst_i) // see [R9]
      (state_r == erase_result_pkg::ST_ERASE && erase_done_i && !erase_fail_i && !ctrl_changed_i && !exec_err_r)
      |-> ##2 result_valid_o && erase_result_byte_o == 8'h00)
      else $error("Clean erase not reported as success");
   a_valid_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // see [R10]
      result_valid_o |=> !result_valid_o)
      else $error("Result valid longer than one cycle");
   a_valid_after_done: assert property (@(posedge clk_i) disable iff (rst_i) // see [R10]
      state_r == erase_result_pkg::ST_DONE |=> result_valid_o)
      else $error("Result valid missing after done");
   a_byte_stable: assert property (@(posedge clk_i) disable iff (rst_i) // see [R10]
      state_r != erase_result_pkg::ST_DONE |=> $stable(erase_result_byte_o))
      else $error("Result byte changed outside done");
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic erase_req_i = 1'b0;
   logic [7:0] block_num_i = 8'h00;
   logic pin = 1'b1;
   logic flag = 1'b0;
   logic [7:0] key = 8'h5a;
   logic [7:0] sel = 8'h00;
   logic ctrl_changed_i = 1'b0;
   logic erase_done_i = 1'b0;
   logic erase_fail_i = 1'b0;
   logic erase_start_o;
   logic busy_o;
   logic result_valid_o;
   logic [7:0] result;
   int fails = 0;
   int comparisons = 0;

   flash_erase_result_status u_dut
   (
      .clk_i(clk_i), .rst_i(rst_i), .erase_req_i(erase_req_i), .block_num_i(block_num_i),
      .flash_write_enable_pin_i(pin), .flash_error_flag_i(flag), .flash_key_register_i(key),
      .array_select_register_i(sel), .ctrl_changed_i(ctrl_changed_i), .erase_done_i(erase_done_i),
      .erase_fail_i(erase_fail_i), .erase_start_o(erase_start_o), .busy_o(busy_o),
      .result_valid_o(result_valid_o), .erase_result_byte_o(result)
   );

   always #50 clk_i = ~clk_i;

   task automatic finish_test();
      if (fails == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One request; erase phase only when the engine was started
   task automatic run(input logic [7:0] blk, input logic [7:0] k, input logic [7:0] s, input logic fl,
                      input logic ef, input logic cc, input logic [7:0] exp);
      logic st;
      int n;
      @(posedge clk_i);
      block_num_i <= blk;
      key <= k;
      sel <= s;
      flag <= fl;
      erase_req_i <= 1'b1;
      #1 st = erase_start_o;
      check("start", {7'h00, st}, {7'h00, (exp & 8'h58) == 8'h00 && s != 8'haa});
      @(posedge clk_i);
      erase_req_i <= 1'b0;
      if (st === 1'b1)
      begin
         ctrl_changed_i <= cc;
         @(posedge clk_i);
         ctrl_changed_i <= 1'b0;
         erase_done_i <= 1'b1;
         erase_fail_i <= ef;
         @(posedge clk_i);
         erase_done_i <= 1'b0;
         erase_fail_i <= 1'b0;
      end
      for (n = 0; n < 20; n++)
      begin
         #1;
         if (result_valid_o === 1'b1)
            break;
         check("busy", {7'h00, busy_o}, 8'h01);
         @(posedge clk_i);
      end
      if (n == 20)
      begin
         fails++;
         finish_test();
      end
      check("result", result, exp);
      check("idle", {7'h00, busy_o}, 8'h00);
   endtask

   task automatic blocks();
      logic [7:0] good [4] = '{8'h00, 8'h0a, 8'h0c, 8'h17};
      logic [7:0] bad [3] = '{8'h0b, 8'h18, 8'hff};
      foreach (good[i]) run(good[i], 8'h5a, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
      foreach (bad[i]) run(bad[i], 8'h5a, 8'h00, 1'b0, 1'b0, 1'b0, 8'h09);
   endtask

   task automatic pin_low();
      @(posedge clk_i);
      pin <= 1'b0;
      repeat (8) @(posedge clk_i);
      run(8'h01, 8'h5a, 8'h00, 1'b0, 1'b0, 1'b0, 8'h41);
      @(posedge clk_i);
      pin <= 1'b1;
      repeat (8) @(posedge clk_i);
      run(8'h01, 8'h5a, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
   endtask

   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      blocks();
      run(8'h02, 8'h5b, 8'h00, 1'b0, 1'b0, 1'b0, 8'h11);
      run(8'h02, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 8'h11);
      run(8'h02, 8'h5a, 8'h00, 1'b1, 1'b0, 1'b0, 8'h41);
      run(8'h02, 8'h5a, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
      pin_low();
      run(8'h03, 8'h5a, 8'haa, 1'b0, 1'b0, 1'b0, 8'h21);
      run(8'h03, 8'h5a, 8'h00, 1'b0, 1'b1, 1'b0, 8'h21);
      run(8'h03, 8'h5a, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
      run(8'h03, 8'h5a, 8'h00, 1'b0, 1'b0, 1'b1, 8'h21);
      run(8'h0b, 8'h11, 8'h00, 1'b1, 1'b0, 1'b0, 8'h59);
      finish_test();
   end
endmodule
